/* File: cbs_map.vh */
`ifndef CBS_MAP_VH
`define CBS_MAP_VH

// register byte offsets, decoded on haddr[7:0]
`define CBS_OFF_CTRL       8'h00
`define CBS_OFF_CUR_ADDR   8'h04
`define CBS_OFF_STATUS     8'h08
`define CBS_OFF_POLL       8'h0c
`define CBS_OFF_HIST       8'h10
`define CBS_OFF_HIST_IDX   8'h14

// control register fields
`define CBS_CTRL_POLL_EN   0
`define CBS_CTRL_CHAIN     1

// status register fields
`define CBS_STA_POLL_DONE  0
`define CBS_STA_SAVED      1
`define CBS_STA_POLL_BUSY  2
`define CBS_STA_CHAINED    3
`define CBS_STA_BYTE_LSB   8

// poll register fields
`define CBS_POLL_PAIR_LSB  16
`define CBS_POLL_VALID     24

// status byte layout
`define CBS_ST_BUSY        0
`define CBS_ST_MODIFIER    1
`define CBS_ST_CTRL_END    2
`define CBS_ST_ATTENTION   3
`define CBS_ST_CHAN_END    4
`define CBS_ST_DEV_END     5
`define CBS_ST_UNIT_CHECK  6
`define CBS_ST_UNIT_EXC    7

// reset values
`define CBS_RST_CTRL       32'h00000000
`define CBS_RST_CUR_ADDR   32'h00000000

// command doubleword stepping
`define CBS_DW_STEP        32'h00000008
`define CBS_SKIP_STEP      32'h00000010

// timing
`define CBS_CLK_PERIOD_PS  5000
`define CBS_POLL_DRIVE_NS  300
`define CBS_POLL_CYC  ((`CBS_POLL_DRIVE_NS * 1000 + `CBS_CLK_PERIOD_PS - 1) / `CBS_CLK_PERIOD_PS)

`endif

/* File: cbs_poll_hist.v */
`timescale 1ns/1ps
`default_nettype none
module cbs_poll_hist #(
	parameter AW = 3,
	parameter DW = 16
) (
	input  wire          core_clk,
	input  wire          rst_n,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= {DW{1'b0}};
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule
`default_nettype wire

/* File: cbs_chan_ctrl.v */
// Behaviour
// [RQ1] each operation ends in device end; chained ones report only the last
// [RQ2] controller drops a command failing at initiation without device end
// [RQ3] controller gives device end with channel end or later
// [RQ4] device end, chaining set, nothing unusual: start next operation
// [RQ5] status modifier plus device end while chaining: fetch address plus 16
// [RQ6] no chaining or unusual condition: no action, status only saved
// [RQ7] controller unit check alone means command aborted before any action
// [RQ8] controller gives no unit check for properly executed commands
// [RQ9] controller gives no unit check on sense of a not ready device
// [RQ10] controller reports execution errors as unit check with an end bit
// [RQ11] controller reports late errors as unit check with attention
// [RQ12] unit check at termination suppresses chaining
// [RQ13] unit exception at termination suppresses chaining
// [RQ14] controller gives unit exception with an end bit
// [RQ15] controller loads state register then drives service request low
// [RQ16] controller holds service request off until end of burst
// [RQ17] controller loads status after serial poll disable for collection
// [RQ18] service request low starts a poll driving attention and identify low; here only with poll enable set and poll done clear
// [RQ19] controllers place priority on data lines within 300 ns
// [RQ20] decode poll into 2 of 16 addresses, store, then release lines
// [RQ21] controllers remove priority within 300 ns after poll ends
// [RQ22] status byte bit order busy through unit exception
// [RQ23] status is taken only while status ready bit is set
// [RQ24] only requesting controllers drive priority during a poll
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "cbs_map.vh"
module cbs_chan_ctrl #(
	parameter HIST_AW = 3
) (
	input  wire        core_clk,
	input  wire        rst_n,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        service_request_line_n,
	input  wire [7:0]  data_lines_n,
	output reg         attention_line_out_n,
	output reg         attention_line_oe_n,
	output reg         end_or_identify_line_out_n,
	output reg         end_or_identify_line_oe_n,
	input  wire        status_strobe,
	input  wire [7:0]  status_byte,
	input  wire        status_ready_bit,
	output reg         chain_start,
	output reg  [31:0] chain_addr,
	output reg  [3:0]  poll_pair_addr,
	output reg         poll_pair_valid
);
	localparam [1:0] ST_IDLE    = 2'h0;
	localparam [1:0] ST_DRIVE   = 2'h1;
	localparam [1:0] ST_RELEASE = 2'h2;
	localparam [31:0] POLL_CYC_W = `CBS_POLL_CYC;
	localparam [7:0]  POLL_CYC   = POLL_CYC_W[7:0];
	localparam [31:0] RST_CTRL   = `CBS_RST_CTRL;

	// one data line per priority: line k covers addresses 2k and 2k+1
	function [15:0] pair_mask;
		input [7:0] lines;
		integer k;
		begin
			pair_mask = 16'h0000;
			for (k = 0; k < 8; k = k + 1) begin
				pair_mask[2*k]   = lines[k];
				pair_mask[2*k+1] = lines[k];
			end
		end
	endfunction

	// lowest asserted line wins the pair selection
	function [2:0] first_line;
		input [7:0] lines;
		integer k;
		begin
			first_line = 3'h0;
			for (k = 7; k >= 0; k = k - 1) begin
				if (lines[k]) begin
					first_line = k[2:0];
				end
			end
		end
	endfunction

	reg  [1:0]         poll_state_reg;
	reg  [7:0]         poll_cnt_reg;
	reg                poll_en_reg;
	reg                chain_en_reg;
	reg  [31:0]        cur_addr_reg;
	reg                poll_done_reg;
	reg                saved_reg;
	reg                chained_reg;
	reg  [7:0]         saved_byte_reg;
	reg  [15:0]        cand_mask_reg;
	reg  [HIST_AW-1:0] hist_wr_reg;
	reg  [HIST_AW-1:0] hist_idx_reg;
	reg                dp_write_reg;
	reg  [7:0]         dp_addr_reg;
	reg                hist_we_reg;
	wire [15:0]        hist_rd;
	wire [7:0]         poll_lines;
	wire               addr_phase;
	wire               wr_ctrl;
	wire               wr_addr;
	wire               wr_status;
	wire               wr_idx;
	wire               st_take;
	wire               st_dev_end;
	wire               st_modifier;
	wire               st_unusual;
	wire               do_chain;
	wire               poll_finish;
	reg  [31:0]        rd_mux;

	assign poll_lines = ~data_lines_n;
	assign addr_phase = hsel & hready & htrans[1];
	assign wr_ctrl    = dp_write_reg & (dp_addr_reg == `CBS_OFF_CTRL);
	assign wr_addr    = dp_write_reg & (dp_addr_reg == `CBS_OFF_CUR_ADDR);
	assign wr_status  = dp_write_reg & (dp_addr_reg == `CBS_OFF_STATUS);
	assign wr_idx     = dp_write_reg & (dp_addr_reg == `CBS_OFF_HIST_IDX);

	assign st_take     = status_strobe & status_ready_bit; // see [RQ23]
	assign st_dev_end  = status_byte[`CBS_ST_DEV_END]; // see [RQ22]
	assign st_modifier = status_byte[`CBS_ST_MODIFIER];
	// attention with device end also suppresses chaining
	assign st_unusual  = status_byte[`CBS_ST_UNIT_CHECK] | // see [RQ12]
	                     status_byte[`CBS_ST_UNIT_EXC] | // see [RQ13]
	                     status_byte[`CBS_ST_ATTENTION];
	assign do_chain    = st_take & st_dev_end & chain_en_reg &
	                     ~st_unusual; // see [RQ4]
	assign poll_finish = (poll_state_reg == ST_DRIVE) &&
	                     (poll_cnt_reg == 8'h00);

	// ahb-lite slave: zero wait states, read data registered in address phase
	always @* begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
		`CBS_OFF_CTRL: begin
			rd_mux[`CBS_CTRL_POLL_EN] = poll_en_reg;
			rd_mux[`CBS_CTRL_CHAIN]   = chain_en_reg;
		end
		`CBS_OFF_CUR_ADDR: begin
			rd_mux = cur_addr_reg;
		end
		`CBS_OFF_STATUS: begin
			rd_mux[`CBS_STA_POLL_DONE] = poll_done_reg;
			rd_mux[`CBS_STA_SAVED]     = saved_reg;
			rd_mux[`CBS_STA_POLL_BUSY] = (poll_state_reg != ST_IDLE);
			rd_mux[`CBS_STA_CHAINED]   = chained_reg;
			rd_mux[`CBS_STA_BYTE_LSB+7:`CBS_STA_BYTE_LSB] = saved_byte_reg;
		end
		`CBS_OFF_POLL: begin
			rd_mux[15:0] = cand_mask_reg;
			rd_mux[`CBS_POLL_PAIR_LSB+3:`CBS_POLL_PAIR_LSB] = poll_pair_addr;
			rd_mux[`CBS_POLL_VALID] = poll_pair_valid;
		end
		`CBS_OFF_HIST: begin
			rd_mux[15:0] = hist_rd;
		end
		`CBS_OFF_HIST_IDX: begin
			rd_mux[HIST_AW-1:0] = hist_idx_reg;
		end
		default: begin
			rd_mux = 32'h00000000;
		end
		endcase
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata       <= 32'h00000000;
			hreadyout    <= 1'b1;
			hresp        <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_addr_reg  <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				dp_write_reg <= addr_phase & hwrite;
				dp_addr_reg  <= haddr[7:0];
				if (addr_phase && !hwrite) begin
					hrdata <= rd_mux;
				end
			end
		end
	end

	// control registers written by software
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			poll_en_reg  <= RST_CTRL[`CBS_CTRL_POLL_EN];
			chain_en_reg <= RST_CTRL[`CBS_CTRL_CHAIN];
			hist_idx_reg <= {HIST_AW{1'b0}};
		end else begin
			if (wr_ctrl) begin
				poll_en_reg  <= hwdata[`CBS_CTRL_POLL_EN];
				chain_en_reg <= hwdata[`CBS_CTRL_CHAIN];
			end
			if (wr_idx) begin
				hist_idx_reg <= hwdata[HIST_AW-1:0];
			end
		end
	end

	// status evaluation and command chaining
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_addr_reg   <= `CBS_RST_CUR_ADDR;
			chain_start    <= 1'b0;
			chain_addr     <= 32'h00000000;
			saved_reg      <= 1'b0;
			chained_reg    <= 1'b0;
			saved_byte_reg <= 8'h00;
		end else begin
			chain_start <= do_chain;
			if (do_chain) begin
				if (st_modifier) begin
					cur_addr_reg <= cur_addr_reg + `CBS_SKIP_STEP; // see [RQ5]
					chain_addr   <= cur_addr_reg + `CBS_SKIP_STEP; // see [RQ5]
				end else begin
					cur_addr_reg <= cur_addr_reg + `CBS_DW_STEP; // see [RQ4]
					chain_addr   <= cur_addr_reg + `CBS_DW_STEP; // see [RQ4]
				end
			end else if (wr_addr) begin
				cur_addr_reg <= hwdata;
			end
			// a chained device end is held back from software
			if (st_take && !do_chain) begin
				saved_byte_reg <= status_byte; // see [RQ1] see [RQ6]
			end
			if (st_take && !do_chain) begin
				saved_reg <= 1'b1; // see [RQ6]
			end else if (wr_status && hwdata[`CBS_STA_SAVED]) begin
				saved_reg <= 1'b0;
			end
			if (do_chain) begin
				chained_reg <= 1'b1;
			end else if (wr_status && hwdata[`CBS_STA_CHAINED]) begin
				chained_reg <= 1'b0;
			end
		end
	end

	// parallel poll sequencer
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			poll_state_reg             <= ST_IDLE;
			poll_cnt_reg               <= 8'h00;
			attention_line_out_n       <= 1'b0;
			attention_line_oe_n        <= 1'b1;
			end_or_identify_line_out_n <= 1'b0;
			end_or_identify_line_oe_n  <= 1'b1;
			poll_done_reg              <= 1'b0;
			cand_mask_reg              <= 16'h0000;
			poll_pair_addr             <= 4'h0;
			poll_pair_valid            <= 1'b0;
			hist_wr_reg                <= {HIST_AW{1'b0}};
			hist_we_reg                <= 1'b0;
		end else begin
			hist_we_reg <= 1'b0;
			case (poll_state_reg)
			ST_IDLE: begin
				if (poll_en_reg && !service_request_line_n &&
				    !poll_done_reg) begin
					attention_line_oe_n       <= 1'b0; // see [RQ18]
					end_or_identify_line_oe_n <= 1'b0; // see [RQ18]
					poll_cnt_reg   <= POLL_CYC - 8'h01; // see [RQ19]
					poll_state_reg <= ST_DRIVE;
				end
			end
			ST_DRIVE: begin
				if (poll_finish) begin
					cand_mask_reg   <= pair_mask(poll_lines); // see [RQ20]
					poll_pair_addr  <= {first_line(poll_lines), 1'b0};
					poll_pair_valid <= |poll_lines;
					hist_we_reg     <= 1'b1;
					attention_line_oe_n       <= 1'b1; // see [RQ20]
					end_or_identify_line_oe_n <= 1'b1; // see [RQ20]
					poll_cnt_reg   <= POLL_CYC - 8'h01; // see [RQ21]
					poll_state_reg <= ST_RELEASE;
				end else begin
					poll_cnt_reg <= poll_cnt_reg - 8'h01;
				end
			end
			ST_RELEASE: begin
				if (poll_cnt_reg == 8'h00) begin
					poll_state_reg <= ST_IDLE;
				end else begin
					poll_cnt_reg <= poll_cnt_reg - 8'h01;
				end
			end
			default: begin
				poll_state_reg <= ST_IDLE;
			end
			endcase
			if (hist_we_reg) begin
				hist_wr_reg <= hist_wr_reg + {{(HIST_AW-1){1'b0}}, 1'b1};
			end
			if (poll_finish) begin
				poll_done_reg <= 1'b1;
			end else if (wr_status && hwdata[`CBS_STA_POLL_DONE]) begin
				poll_done_reg <= 1'b0;
			end
		end
	end

	cbs_poll_hist #(
		.AW (HIST_AW),
		.DW (16)
	) u_hist (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.wr_en    (hist_we_reg),
		.wr_addr  (hist_wr_reg),
		.wr_data  (cand_mask_reg),
		.rd_addr  (hist_idx_reg),
		.rd_data  (hist_rd)
	);
endmodule
`default_nettype wire

/* File: cbs_chan_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module cbs_chan_ctrl_monitor (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        service_request_line_n,
	input wire logic [7:0]  data_lines_n,
	input wire logic        attention_line_oe_n,
	input wire logic        end_or_identify_line_oe_n,
	input wire logic        status_strobe,
	input wire logic [7:0]  status_byte,
	input wire logic        status_ready_bit,
	input wire logic        chain_start,
	input wire logic [31:0] chain_addr,
	input wire logic [3:0]  poll_pair_addr,
	input wire logic        poll_pair_valid
);
	logic        wr_ctrl_reg;
	logic        wr_addr_reg;
	logic        chain_on_reg;
	logic [31:0] addr_reg;
	logic [6:0]  drive_cnt_reg;
	wire         take = status_strobe && status_ready_bit;
	wire         go = take && chain_on_reg && status_byte[5] &&
		!(status_byte[3] || status_byte[6] || status_byte[7]);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// shadows of the chain enable bit and the doubleword address
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ctrl_reg <= 1'b0;
			wr_addr_reg <= 1'b0;
			chain_on_reg <= 1'b0;
			addr_reg <= 32'h0;
			drive_cnt_reg <= 7'h0;
		end else begin
			wr_ctrl_reg <= hsel && hready && htrans[1] && hwrite &&
				haddr[7:0] == 8'h00;
			wr_addr_reg <= hsel && hready && htrans[1] && hwrite &&
				haddr[7:0] == 8'h04;
			if (wr_ctrl_reg)
				chain_on_reg <= hwdata[1];
			// a chain step wins over a software load in the same cycle
			if (go)
				addr_reg <= addr_reg + (status_byte[1] ? 32'h10 : 32'h8);
			else if (wr_addr_reg)
				addr_reg <= hwdata;
			drive_cnt_reg <= attention_line_oe_n ? 7'h0 : drive_cnt_reg + 7'h1;
		end
	end
	function automatic logic [3:0] first_pair(input logic [7:0] l);
		first_pair = 4'h0;
		for (int k = 7; k >= 0; k--)
			if (!l[k])
				first_pair = {k[2:0], 1'b0};
	endfunction
	sequence s_poll_open;
		$fell(attention_line_oe_n);
	endsequence
	sequence s_poll_close;
		$rose(attention_line_oe_n);
	endsequence
	a_chain_next: assert property (go && !status_byte[1] |=>
		chain_start && chain_addr == $past(addr_reg) + 32'h8)
		else $error("chain step of 8 wrong");
	a_chain_skip: assert property (go && status_byte[1] |=>
		chain_start && chain_addr == $past(addr_reg) + 32'h10)
		else $error("chain skip of 16 wrong");
	a_chain_off: assert property (
		take && !chain_on_reg |=> !chain_start)
		else $error("chain without chaining enabled");
	a_check_stops: assert property (
		take && status_byte[6] |=> !chain_start)
		else $error("chain after unit check");
	a_exc_stops: assert property (
		take && status_byte[7] |=> !chain_start)
		else $error("chain after unit exception");
	a_need_dev_end: assert property (
		take && !status_byte[5] |=> !chain_start)
		else $error("chain without device end");
	a_ready_gate: assert property (!take |=> !chain_start)
		else $error("chain without accepted status");
	a_poll_cause: assert property (s_poll_open |->
		!end_or_identify_line_oe_n && !$past(service_request_line_n))
		else $error("poll start wrong");
	a_poll_length: assert property (s_poll_close |->
		drive_cnt_reg == 7'd60 && end_or_identify_line_oe_n)
		else $error("poll drive length wrong");
	a_poll_result: assert property (s_poll_close |->
		poll_pair_valid == ($past(data_lines_n) != 8'hff) &&
		poll_pair_addr == first_pair($past(data_lines_n)))
		else $error("poll result wrong");
endmodule
bind cbs_chan_ctrl cbs_chan_ctrl_monitor u_mon (
	.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
	.service_request_line_n, .data_lines_n, .attention_line_oe_n,
	.end_or_identify_line_oe_n, .status_strobe, .status_byte,
	.status_ready_bit, .chain_start, .chain_addr, .poll_pair_addr,
	.poll_pair_valid
);
`default_nettype wire

/* File: cbs_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cbs_ctrl_model (
	input  wire logic        core_clk,
	input  wire logic [15:0] req_mask,
	input  wire logic [6:0]  resp_dly,
	input  wire logic        attention_line,
	input  wire logic        end_or_identify_line,
	output wire logic        service_request_line_n,
	output wire logic [7:0]  data_lines_n
);
	logic [6:0] on_cnt = 7'h0;
	logic [6:0] off_cnt = 7'h0;
	logic       drv = 1'b0;
	logic [7:0] prio;
	// unknown lines before reset count as no poll
	wire        in_poll = attention_line === 1'b0 &&
		end_or_identify_line === 1'b0;
	always_comb begin
		for (int k = 0; k < 8; k++)
			prio[k] = req_mask[2*k] || req_mask[2*k+1];
	end
	assign service_request_line_n = ~|req_mask;
	// released lines float up to the pull-up level
	assign data_lines_n = drv ? ~prio : 8'hff;
	always @(posedge core_clk) begin
		on_cnt <= in_poll ? on_cnt + 7'h1 : 7'h0;
		off_cnt <= in_poll ? 7'h0 : off_cnt + 7'h1;
		drv <= in_poll ? on_cnt >= resp_dly : drv && off_cnt < resp_dly;
	end
endmodule
`default_nettype wire

/* File: cbs_chan_ctrl_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module cbs_chan_ctrl_bench;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        service_request_line_n;
	logic [7:0]  data_lines_n;
	logic        attention_line_out_n;
	logic        attention_line_oe_n;
	logic        end_or_identify_line_out_n;
	logic        end_or_identify_line_oe_n;
	logic        status_strobe = 1'b0;
	logic [7:0]  status_byte = 8'h0;
	logic        status_ready_bit = 1'b0;
	logic        chain_start;
	logic [31:0] chain_addr;
	logic [3:0]  poll_pair_addr;
	logic        poll_pair_valid;
	logic [15:0] req_mask = 16'h0;
	logic [6:0]  resp_dly = 7'h2;
	logic [31:0] rd;
	int          bad_count = 0;
	int          total_checks = 0;
	wire logic   attention_line = attention_line_oe_n | attention_line_out_n;
	wire logic   end_or_identify_line = end_or_identify_line_oe_n |
		end_or_identify_line_out_n;
	always #2.5 core_clk = ~core_clk;
	cbs_chan_ctrl dut (
		.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.service_request_line_n, .data_lines_n, .attention_line_out_n,
		.attention_line_oe_n, .end_or_identify_line_out_n,
		.end_or_identify_line_oe_n, .status_strobe, .status_byte,
		.status_ready_bit, .chain_start, .chain_addr, .poll_pair_addr,
		.poll_pair_valid
	);
	cbs_ctrl_model model (
		.core_clk, .req_mask, .resp_dly, .attention_line,
		.end_or_identify_line, .service_request_line_n, .data_lines_n
	);
	task automatic wrap_up;
		if (bad_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic hold(input string what);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk(what, 1, 0);
			wrap_up;
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		hold("address phase");
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		hold("data phase");
		rd = hrdata;
	endtask
	task automatic send(input logic [7:0] b, input logic rdy);
		@(posedge core_clk);
		status_strobe <= 1'b1;
		status_byte <= b;
		status_ready_bit <= rdy;
		@(posedge core_clk);
		status_strobe <= 1'b0;
		#1;
	endtask
	task automatic wait_line(input logic lvl);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (attention_line_oe_n !== lvl && n < 400);
		if (n >= 400) begin
			chk("poll line wait", 1, 0);
			wrap_up;
		end
	endtask
	task automatic t_regs;
		chk("hresp", 0, hresp);
		chk("attention idle", 1, attention_line_oe_n);
		chk("identify idle", 1, end_or_identify_line_oe_n);
		chk("chain_addr reset", 0, chain_addr);
		chk("pair valid reset", 0, poll_pair_valid);
		ahb(1'b0, 8'h00, 0);
		chk("ctrl reset", 0, rd);
		ahb(1'b1, 8'h18, 32'hffffffff);
		ahb(1'b0, 8'h18, 0);
		chk("unmapped read", 0, rd);
	endtask
	task automatic t_chain;
		logic [7:0]  b [8] = '{
			8'h20, 8'h22,
			8'h60, 8'ha0, 8'h28,
			8'h10, 8'h40, 8'h48};
		logic [31:0] ea;
		logic        go;
		ea = 32'h0;
		ahb(1'b1, 8'h00, 32'h2);
		foreach (b[i]) begin
			go = b[i][5] && !(b[i][3] || b[i][6] || b[i][7]);
			if (go)
				ea = ea + (b[i][1] ? 32'h10 : 32'h8);
			send(b[i], 1'b1);
			chk("chain_start", go, chain_start);
			chk("chain_addr", ea, chain_addr);
		end
		ahb(1'b0, 8'h04, 0);
		chk("cur addr", ea, rd);
		ahb(1'b1, 8'h04, 32'h100);
		send(8'h22, 1'b1);
		chk("chain_start", 1, chain_start);
		chk("chain_addr", 32'h110, chain_addr);
		ahb(1'b1, 8'h08, 32'hf);
	endtask
	task automatic t_plain;
		ahb(1'b1, 8'h00, 32'h0);
		send(8'h22, 1'b1);
		chk("chain_start", 0, chain_start);
		ahb(1'b0, 8'h08, 0);
		chk("saved status", 32'h2202, rd & 32'hff02);
		ahb(1'b1, 8'h08, 32'h2);
		send(8'h20, 1'b0);
		ahb(1'b0, 8'h08, 0);
		chk("ignored status", 32'h2200, rd & 32'hff02);
	endtask
	task automatic t_poll(input logic [15:0] m, input logic [6:0] dly,
		input logic [3:0] pair, input logic [31:0] reg_val);
		int n;
		req_mask <= m;
		resp_dly <= dly;
		ahb(1'b1, 8'h00, 32'h1);
		wait_line(1'b0);
		chk("identify driven", 0, end_or_identify_line_oe_n);
		chk("attention low", 0, attention_line);
		chk("identify low", 0, end_or_identify_line);
		wait_line(1'b1);
		chk("pair addr", pair, poll_pair_addr);
		chk("pair valid", 1, poll_pair_valid);
		ahb(1'b0, 8'h0c, 0);
		chk("poll reg", reg_val, rd);
		ahb(1'b0, 8'h08, 0);
		chk("poll done", 1, rd & 32'h1);
		chk("poll busy", 32'h4, rd & 32'h4);
		n = 0;
		repeat (130) begin
			@(posedge core_clk);
			n += !attention_line_oe_n;
		end
		chk("poll refused", 0, n);
		req_mask <= 16'h0;
		ahb(1'b1, 8'h08, 32'h1);
	endtask
	task automatic t_hist;
		ahb(1'b1, 8'h14, 32'h0);
		ahb(1'b0, 8'h10, 0);
		chk("history 0", 32'h3030, rd);
		ahb(1'b1, 8'h14, 32'h9);
		ahb(1'b0, 8'h14, 0);
		chk("history index", 32'h1, rd);
		ahb(1'b0, 8'h10, 0);
		chk("history 1", 32'hc003, rd);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs;
		t_chain;
		t_plain;
		t_poll(16'h1020, 7'd2, 4'h4, 32'h01043030);
		t_poll(16'h8001, 7'd55, 4'h0, 32'h0100c003);
		t_hist;
		wrap_up;
	end
endmodule
`default_nettype wire
